// *** design/tpc_pkg.sv ***
package tpc_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned T3_W = 16;
    localparam int unsigned PORT_W = 8;

    // ------------------------------------------------------------------
    // Register indices on the plain register port
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CFG = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_PC_LOW = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_PC_HIGH = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_T3_LOW = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_T3_HIGH = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_T1 = 3'h6;
    localparam logic [ADDR_W-1:0] ADDR_T2 = 3'h7;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned BIT_SECOND_PWM = 5;
    localparam int unsigned BIT_FIRST_PWM = 4;
    localparam int unsigned BIT_CAP_SEL = 3;
    localparam int unsigned BIT_THIRD_RUN = 2;
    localparam int unsigned BIT_SECOND_RUN = 1;
    localparam int unsigned BIT_CASCADE = 0;
    localparam int unsigned BIT_FIRST_RUN = 1;
    localparam int unsigned PIN_PWM_A = 2;
    localparam int unsigned PIN_PWM_B = 3;

    // ------------------------------------------------------------------
    // Masks and reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] CTRL_WMASK = 8'h3E;
    localparam logic [DATA_W-1:0] CFG_WMASK = 8'h03;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
    localparam logic [T3_W-1:0] PC_RESET = 16'hFFFF;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned TICK_DIV_DEFAULT = 4;

endpackage

// *** design/tpc_counter.sv ***
`timescale 1ns/1ns
module tpc_counter #(
    parameter int unsigned W = 8
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_inc,
    input wire logic i_clear,
    input wire logic i_load,
    input wire logic [W-1:0] i_load_val,
    output logic [W-1:0] o_count,
    output logic o_wrap
);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;

    // Bus load wins over counting so software always sees what it wrote
    always_comb
    begin
        count_d = count_q;
        if (i_load)
        begin
            count_d = i_load_val;
        end
        else if (i_clear)
        begin
            count_d = '0;
        end
        else if (i_inc)
        begin
            count_d = count_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            count_q <= '0;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    assign o_count = count_q;
    assign o_wrap = i_inc & (&count_q);

endmodule

// *** design/tpc_top.sv ***
`timescale 1ns/1ns
// What this block does
// - Second PWM enable forces pin3 output
// - First PWM enable forces pin2 output
// - Select 1: pair captures, timer3 free-runs
// - Select 0: pair is timer3 period
// - Timer3 counts only while run bit set
// - Second timer counts only while run set
module tpc_top
    import tpc_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_DIV_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [tpc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [tpc_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [tpc_pkg::DATA_W-1:0] o_rdata,
    input wire logic [tpc_pkg::PORT_W-1:0] i_port_b_direction_bits,
    input wire logic [tpc_pkg::PORT_W-1:0] i_port_b_latch,
    input wire logic i_pwm_a,
    input wire logic i_pwm_b,
    input wire logic i_capture1_pin,
    output logic o_port_b_pin2_pwm_a_out,
    output logic o_port_b_pin2_pwm_a_oe,
    output logic o_port_b_pin3_pwm_b_out,
    output logic o_port_b_pin3_pwm_b_oe
);
    import tpc_pkg::*;

    localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] ctrl_d;
    logic [DATA_W-1:0] cfg_q;
    logic [DATA_W-1:0] cfg_d;
    logic [T3_W-1:0] pc_q;
    logic [T3_W-1:0] pc_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [T3_W-1:0] t3_count;
    logic [DATA_W-1:0] t1_count;
    logic [DATA_W-1:0] t2_count;
    logic cap_edge;
    logic second_pwm_enable;
    logic first_pwm_enable;
    logic capture_or_period_select;
    logic third_timer_run;
    logic second_timer_run;
    logic timer_cascade_select;
    logic first_timer_run;

    assign second_pwm_enable = ctrl_q[BIT_SECOND_PWM];
    assign first_pwm_enable = ctrl_q[BIT_FIRST_PWM];
    assign capture_or_period_select = ctrl_q[BIT_CAP_SEL];
    assign third_timer_run = ctrl_q[BIT_THIRD_RUN];
    assign second_timer_run = ctrl_q[BIT_SECOND_RUN];
    assign timer_cascade_select = cfg_q[BIT_CASCADE];
    assign first_timer_run = cfg_q[BIT_FIRST_RUN];

    always_comb
    begin
        ctrl_d = ctrl_q;
        cfg_d = cfg_q;
        pc_d = pc_q;
        rdata_d = ZERO_BYTE;
        if (i_wr && i_addr == ADDR_CTRL)
        begin
            ctrl_d = i_wdata & CTRL_WMASK;
        end
        if (i_wr && i_addr == ADDR_CFG)
        begin
            cfg_d = i_wdata & CFG_WMASK;
        end
        if (i_wr && i_addr == ADDR_PC_LOW)
        begin
            pc_d[DATA_W-1:0] = i_wdata;
        end
        if (i_wr && i_addr == ADDR_PC_HIGH)
        begin
            pc_d[T3_W-1:DATA_W] = i_wdata;
        end
        // Capture beats a same-cycle bus write: the event is never lost
        if (capture_or_period_select && cap_edge)
        begin
            pc_d = t3_count;
        end
        if (i_rd)
        begin
            case (i_addr)
                ADDR_CTRL: rdata_d = ctrl_q;
                ADDR_CFG: rdata_d = cfg_q;
                ADDR_PC_LOW: rdata_d = pc_q[DATA_W-1:0];
                ADDR_PC_HIGH: rdata_d = pc_q[T3_W-1:DATA_W];
                ADDR_T3_LOW: rdata_d = t3_count[DATA_W-1:0];
                ADDR_T3_HIGH: rdata_d = t3_count[T3_W-1:DATA_W];
                ADDR_T1: rdata_d = t1_count;
                ADDR_T2: rdata_d = t2_count;
                default: rdata_d = ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ctrl_q <= CTRL_RESET;
            cfg_q <= CFG_RESET;
            pc_q <= PC_RESET;
            rdata_q <= ZERO_BYTE;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            cfg_q <= cfg_d;
            pc_q <= pc_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

    // ------------------------------------------------------------------
    // Tick divider and capture pin synchroniser
    // ------------------------------------------------------------------
    logic [7:0] div_q;
    logic [7:0] div_d;
    logic tick;
    logic cap_s1_q;
    logic cap_s2_q;
    logic cap_s3_q;

    assign tick = (div_q == TICK_LAST);

    always_comb
    begin
        div_d = tick ? 8'h00 : div_q + 8'h01;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            div_q <= 8'h00;
            cap_s1_q <= 1'b0;
            cap_s2_q <= 1'b0;
            cap_s3_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            cap_s1_q <= i_capture1_pin;
            cap_s2_q <= cap_s1_q;
            cap_s3_q <= cap_s2_q;
        end
    end

    assign cap_edge = cap_s2_q & ~cap_s3_q;

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    logic t3_inc;
    logic t3_clear;
    logic t3_load;
    logic [T3_W-1:0] t3_load_val;
    logic t1_inc;
    logic t1_wrap;
    logic t1_load;
    logic t2_inc;
    logic t2_load;

    assign t3_inc = tick & third_timer_run;
    // Period match only limits the count in period mode
    assign t3_clear = t3_inc & ~capture_or_period_select & (t3_count == pc_q);
    assign t3_load = i_wr & ((i_addr == ADDR_T3_LOW) | (i_addr == ADDR_T3_HIGH));
    assign t3_load_val = (i_addr == ADDR_T3_LOW) ? {t3_count[T3_W-1:DATA_W], i_wdata}
                                                 : {i_wdata, t3_count[DATA_W-1:0]};
    assign t1_inc = tick & first_timer_run;
    assign t1_load = i_wr & (i_addr == ADDR_T1);
    assign t2_load = i_wr & (i_addr == ADDR_T2);
    // Cascaded: upper byte steps on lower-byte wrap, still gated by its run bit
    assign t2_inc = second_timer_run & (timer_cascade_select ? t1_wrap : tick);

    tpc_counter #(
        .W(T3_W)
    ) u_third_timer (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_inc(t3_inc),
        .i_clear(t3_clear),
        .i_load(t3_load),
        .i_load_val(t3_load_val),
        .o_count(t3_count),
        .o_wrap()
    );

    tpc_counter #(
        .W(DATA_W)
    ) u_first_timer (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_inc(t1_inc),
        .i_clear(1'b0),
        .i_load(t1_load),
        .i_load_val(i_wdata),
        .o_count(t1_count),
        .o_wrap(t1_wrap)
    );

    tpc_counter #(
        .W(DATA_W)
    ) u_second_timer (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_inc(t2_inc),
        .i_clear(1'b0),
        .i_load(t2_load),
        .i_load_val(i_wdata),
        .o_count(t2_count),
        .o_wrap()
    );

    // ------------------------------------------------------------------
    // Pin steering
    // ------------------------------------------------------------------
    logic pin2_out_q;
    logic pin2_out_d;
    logic pin2_oe_q;
    logic pin2_oe_d;
    logic pin3_out_q;
    logic pin3_out_d;
    logic pin3_oe_q;
    logic pin3_oe_d;

    // Direction bit 0 means output, as in the port logic
    always_comb
    begin
        pin2_oe_d = first_pwm_enable | ~i_port_b_direction_bits[PIN_PWM_A];
        pin2_out_d = first_pwm_enable ? i_pwm_a : i_port_b_latch[PIN_PWM_A];
        pin3_oe_d = second_pwm_enable | ~i_port_b_direction_bits[PIN_PWM_B];
        pin3_out_d = second_pwm_enable ? i_pwm_b : i_port_b_latch[PIN_PWM_B];
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pin2_out_q <= 1'b0;
            pin2_oe_q <= 1'b0;
            pin3_out_q <= 1'b0;
            pin3_oe_q <= 1'b0;
        end
        else
        begin
            pin2_out_q <= pin2_out_d;
            pin2_oe_q <= pin2_oe_d;
            pin3_out_q <= pin3_out_d;
            pin3_oe_q <= pin3_oe_d;
        end
    end

    assign o_port_b_pin2_pwm_a_out = pin2_out_q;
    assign o_port_b_pin2_pwm_a_oe = pin2_oe_q;
    assign o_port_b_pin3_pwm_b_out = pin3_out_q;
    assign o_port_b_pin3_pwm_b_oe = pin3_oe_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    sequence s_t3_step;
        t3_inc && !t3_load;
    endsequence

    sequence s_capture_event;
        capture_or_period_select && cap_edge;
    endsequence

    sequence s_cascade_carry;
        timer_cascade_select && second_timer_run && t1_inc && (t1_count == 8'hFF) && !t1_load && !t2_load;
    endsequence

    // Flops stay cleared at the edge that releases reset, so that edge starts no check
    a_pin2_direction: assert property (
        i_arst_n |=> pin2_oe_q == ($past(first_pwm_enable) | ~$past(i_port_b_direction_bits[PIN_PWM_A])))
        else $error("pin2 enable not steered by first pwm enable");

    a_pin3_direction: assert property (
        second_pwm_enable && $past(second_pwm_enable) |-> pin3_oe_q)
        else $error("pin3 not driven while second pwm enabled");

    a_t3_period_wrap: assert property (
        s_t3_step ##0 (!capture_or_period_select && t3_count == pc_q) |=> t3_count == 16'h0000)
        else $error("timer3 did not wrap at period");

    a_t3_free_run: assert property (
        s_t3_step ##0 (capture_or_period_select && t3_count == pc_q && t3_count != 16'hFFFF)
        |=> t3_count == $past(t3_count) + 16'h0001)
        else $error("timer3 limited by period in capture mode");

    a_capture_take: assert property (
        s_capture_event |=> pc_q == $past(t3_count))
        else $error("capture pair missed timer3 value");

    a_t3_stop_hold: assert property (
        (!third_timer_run && !t3_load) [*3] |=> $stable(t3_count))
        else $error("timer3 moved while stopped");

    a_t2_gate_hold: assert property (
        !second_timer_run && !t2_load |=> $stable(t2_count))
        else $error("second timer moved while stopped");

    a_t2_cascade_step: assert property (
        s_cascade_carry |=> (t2_count == $past(t2_count) + 8'h01) && (t1_count == 8'h00))
        else $error("cascaded upper byte did not advance");

endmodule

// *** verif/test_tpc_top.sv ***
`timescale 1ns/1ns
module test_tpc_top;
    import tpc_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] dir;
        logic [7:0] latch;
        logic pwm_a;
        logic pwm_b;
        logic [3:0] pins;
    } tpc_row_t;

    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [ADDR_W-1:0] i_addr = 3'h0;
    logic [DATA_W-1:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [DATA_W-1:0] o_rdata;
    logic [PORT_W-1:0] i_dir = 8'hFF;
    logic [PORT_W-1:0] i_latch = 8'h00;
    logic i_pwm_a = 1'b0;
    logic i_pwm_b = 1'b0;
    logic i_cap = 1'b0;
    logic a_out, a_oe, b_out, b_oe;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] va, vb;
    tpc_row_t rows [6];

    // Tick every clock so counts move one per cycle
    tpc_top #(.TICK_DIV(1)) dut (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_port_b_direction_bits(i_dir), .i_port_b_latch(i_latch),
        .i_pwm_a(i_pwm_a), .i_pwm_b(i_pwm_b), .i_capture1_pin(i_cap),
        .o_port_b_pin2_pwm_a_out(a_out), .o_port_b_pin2_pwm_a_oe(a_oe),
        .o_port_b_pin3_pwm_b_out(b_out), .o_port_b_pin3_pwm_b_oe(b_oe)
    );

    initial
    begin
        forever #2 i_clk = ~i_clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic conclude();
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the read edge
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic do_reset();
        @(posedge i_clk);
        i_arst_n <= 1'b0;
        repeat (10) @(posedge i_clk);
        i_arst_n <= 1'b1;
    endtask

    // Capture pin is synchronised, so hold the level for several cycles
    task automatic pulse_cap();
        @(posedge i_clk);
        i_cap <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_cap <= 1'b0;
        repeat (5) @(posedge i_clk);
    endtask

    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        // pins = {b_oe, b_out, a_oe, a_out}
        rows[0] = '{8'h00, 8'hFF, 8'h00, 1'b1, 1'b1, 4'b0000};
        rows[1] = '{8'h00, 8'hF3, 8'h0C, 1'b0, 1'b0, 4'b1111};
        rows[2] = '{8'h10, 8'hFF, 8'h00, 1'b1, 1'b1, 4'b0011};
        rows[3] = '{8'h20, 8'hFF, 8'h0C, 1'b0, 1'b0, 4'b1001};
        rows[4] = '{8'h30, 8'hFF, 8'h00, 1'b0, 1'b1, 4'b1110};
        rows[5] = '{8'h30, 8'h00, 8'h0C, 1'b1, 1'b0, 4'b1011};
        do_reset();
        foreach (rows[i])
        begin
            wr(ADDR_CTRL, rows[i].ctrl);
            i_dir <= rows[i].dir;
            i_latch <= rows[i].latch;
            i_pwm_a <= rows[i].pwm_a;
            i_pwm_b <= rows[i].pwm_b;
            repeat (2) @(posedge i_clk);
            #1 chk("pins", {b_oe, b_out, a_oe, a_out}, rows[i].pins);
        end

        // Reset in mid-run restores ctrl, the pair and the timer3 low byte
        do_reset();
        rd(ADDR_CTRL, va);
        chk("ctrl reset", va, 8'h00);
        rd(ADDR_PC_LOW, va);
        rd(ADDR_PC_HIGH, vb);
        chk("pair reset", {vb, va}, PC_RESET);
        rd(ADDR_T3_LOW, va);
        chk("timer3 reset", va, 8'h00);
        @(posedge i_clk);
        #1 chk("rdata idle", o_rdata, 8'h00);
        wr(ADDR_CTRL, 8'hFF);
        rd(ADDR_CTRL, va);
        chk("ctrl mask", va, CTRL_WMASK);
        wr(ADDR_CTRL, 8'h00);

        // Run bit gates timer3
        wr(ADDR_T3_HIGH, 8'h00);
        wr(ADDR_T3_LOW, 8'h00);
        wr(ADDR_CTRL, 8'h04);
        rd(ADDR_T3_LOW, va);
        rd(ADDR_T3_LOW, vb);
        chk("timer3 running", vb - va, 8'h02);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_T3_LOW, va);
        rd(ADDR_T3_LOW, vb);
        chk("timer3 stopped", vb - va, 8'h00);

        // Period mode: count never passes the pair, capture ignored
        wr(ADDR_PC_LOW, 8'h03);
        wr(ADDR_PC_HIGH, 8'h00);
        wr(ADDR_T3_HIGH, 8'h00);
        wr(ADDR_T3_LOW, 8'h00);
        wr(ADDR_CTRL, 8'h04);
        repeat (6)
        begin
            rd(ADDR_T3_LOW, va);
            chk("period bound", va < 8'h04, 1'b1);
        end
        pulse_cap();
        rd(ADDR_PC_LOW, va);
        chk("period kept", va, 8'h03);

        // Capture mode: free run past the pair value, then capture a frozen count
        wr(ADDR_CTRL, 8'h0C);
        wr(ADDR_T3_LOW, 8'h02);
        rd(ADDR_T3_LOW, va);
        rd(ADDR_T3_LOW, vb);
        chk("free run", (vb - va == 8'h02) && (vb > 8'h03), 1'b1);
        wr(ADDR_CTRL, 8'h08);
        wr(ADDR_T3_HIGH, 8'h12);
        wr(ADDR_T3_LOW, 8'h34);
        pulse_cap();
        rd(ADDR_PC_LOW, va);
        rd(ADDR_PC_HIGH, vb);
        chk("capture", {vb, va}, 16'h1234);

        // Second timer gated by its run bit
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_T2, 8'h05);
        rd(ADDR_T2, va);
        rd(ADDR_T2, vb);
        chk("timer2 stopped", {va, vb}, 16'h0505);
        wr(ADDR_CTRL, 8'h02);
        rd(ADDR_T2, va);
        rd(ADDR_T2, vb);
        chk("timer2 running", vb - va, 8'h02);

        // Cascade: upper byte frozen until its run bit is set
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_T2, 8'h05);
        wr(ADDR_CFG, 8'hFF);
        rd(ADDR_CFG, va);
        chk("cfg mask", va, CFG_WMASK);
        repeat (600) @(posedge i_clk);
        rd(ADDR_T2, va);
        chk("cascade frozen", va, 8'h05);
        wr(ADDR_CTRL, 8'h02);
        repeat (600) @(posedge i_clk);
        rd(ADDR_T2, va);
        chk("cascade advances", (va > 8'h05) && (va < 8'h09), 1'b1);
        conclude();
    end
endmodule
